/* File: shared/or_ret_pkg.sv */
// constants and types for the or/return instruction execution block
package or_ret_pkg;
	localparam int DATA_W = 8;
	localparam int PC_W   = 13;

	// instruction group decoded upstream, one code per form
	typedef enum logic [2:0] {
		OP_NOP,
		OP_OR_MEM_TO_ACC,
		OP_OR_IMM_TO_ACC,
		or_into_memory_op,
		OP_RET,
		OP_RET_IMM,
		return_from_interrupt_op
	} op_t;

	localparam logic [DATA_W-1:0] ACC_RESET  = 8'h00;
	localparam logic [PC_W-1:0]   PC_RESET   = 13'h0000;
	localparam logic              ZERO_RESET = 1'b0;
	localparam logic              MIE_RESET  = 1'b0;
endpackage

/* File: rtl/or_and_return_instruction_exec.sv */
// execution unit for no-op, or forms and return forms
//
// Operation
// (RL1) a no-op changes no register, memory or flag and the program counter steps on.
// (RL2) or of memory into accumulator writes acc|mem to the accumulator and updates zero.
// (RL3) or of immediate into accumulator writes acc|imm to the accumulator and updates zero.
// (RL4) or into memory writes acc|mem back to memory, keeps the accumulator, updates zero.
// (RL5) plain return pops the program counter and changes no flag.
// (RL6) return with immediate pops the counter and loads the immediate into the accumulator.
// (RL7) return from interrupt pops the counter, re-enables interrupts, and a pending one runs first.
// (RL8) return from interrupt sets the master enable to one without touching status flags.
// (RL9) the master enable gates every interrupt entry.
// (RL10) zero is set when an or result is zero and cleared otherwise; other flags stay.
`timescale 1ns/1ps
module or_and_return_instruction_exec (
	input  wire logic                            clk,
	input  wire logic                            resetn,
	input  wire logic                            exec_valid,
	input  wire or_ret_pkg::op_t                 exec_op,
	input  wire logic [or_ret_pkg::DATA_W-1:0]   imm_data,
	input  wire logic [or_ret_pkg::DATA_W-1:0]   mem_rdata,
	input  wire logic [or_ret_pkg::PC_W-1:0]     stack_top,
	input  wire logic [or_ret_pkg::PC_W-1:0]     isr_vector,
	input  wire logic                            irq_pending,
	input  wire logic                            mie_clear,
	output logic      [or_ret_pkg::DATA_W-1:0]   acc,
	output logic                                 zero_flag,
	output logic                                 master_interrupt_enable,
	output logic      [or_ret_pkg::PC_W-1:0]     pc,
	output logic                                 stack_pop,
	output logic                                 stack_push,
	output logic      [or_ret_pkg::PC_W-1:0]     stack_push_data,
	output logic                                 mem_we,
	output logic      [or_ret_pkg::DATA_W-1:0]   mem_wdata,
	output logic                                 isr_enter
);
	logic [or_ret_pkg::DATA_W-1:0] acc_r,  acc_nxt;
	logic                          zero_r, zero_nxt;
	logic                          mie_r,  mie_nxt;
	logic [or_ret_pkg::PC_W-1:0]   pc_r,   pc_nxt;
	logic                          pop_r,  pop_nxt;
	logic                          push_r, push_nxt;
	logic [or_ret_pkg::PC_W-1:0]   pdat_r, pdat_nxt;
	logic                          we_r,   we_nxt;
	logic [or_ret_pkg::DATA_W-1:0] wd_r,   wd_nxt;
	logic                          isr_r,  isr_nxt;
	logic [or_ret_pkg::DATA_W-1:0] or_mem, or_imm;
	logic [or_ret_pkg::PC_W-1:0]   ret_pc;

	// one zero test shared by the three or forms and their checks
	function automatic logic is_zero(input logic [or_ret_pkg::DATA_W-1:0] v);
		return v == 8'h00;
	endfunction

	// both or results are always formed; the case only picks one
	assign or_mem = acc_r | mem_rdata;
	assign or_imm = acc_r | imm_data;

	always_comb begin
		acc_nxt  = acc_r;
		zero_nxt = zero_r;
		mie_nxt  = mie_r;
		pc_nxt   = pc_r;
		pop_nxt  = 1'b0;
		push_nxt = 1'b0;
		pdat_nxt = pdat_r;
		we_nxt   = 1'b0;
		wd_nxt   = wd_r;
		isr_nxt  = 1'b0;
		ret_pc   = pc_r;
		// return from interrupt is decoded below the clear, so its set wins a shared cycle
		if (mie_clear) begin
			mie_nxt = 1'b0;
		end
		if (exec_valid) begin
			// wraps at the top of program space; there is no overflow flag
			pc_nxt = pc_r + 13'h0001; // [RL1]
			unique case (exec_op)
				or_ret_pkg::OP_NOP: begin
				end
				or_ret_pkg::OP_OR_MEM_TO_ACC: begin
					acc_nxt  = or_mem; // [RL2]
					zero_nxt = is_zero(or_mem); // [RL10]
				end
				or_ret_pkg::OP_OR_IMM_TO_ACC: begin
					acc_nxt  = or_imm; // [RL3]
					zero_nxt = is_zero(or_imm); // [RL10]
				end
				or_ret_pkg::or_into_memory_op: begin
					we_nxt   = 1'b1; // [RL4]
					wd_nxt   = or_mem;
					zero_nxt = is_zero(or_mem); // [RL10]
				end
				or_ret_pkg::OP_RET: begin
					pop_nxt = 1'b1; // [RL5]
					pc_nxt  = stack_top;
				end
				or_ret_pkg::OP_RET_IMM: begin
					pop_nxt = 1'b1; // [RL6]
					pc_nxt  = stack_top;
					acc_nxt = imm_data;
				end
				or_ret_pkg::return_from_interrupt_op: begin
					pop_nxt = 1'b1; // [RL7]
					mie_nxt = 1'b1; // [RL8]
					pc_nxt  = stack_top;
				end
				default: begin
				end
			endcase
		end
		ret_pc = pc_nxt;
		// pending interrupt wins over the next fetch, even right after a return
		// isr_r blocks a second entry in the very next cycle
		if (mie_nxt && irq_pending && !isr_r) begin // [RL9] [RL7]
			isr_nxt  = 1'b1;
			push_nxt = 1'b1;
			pdat_nxt = ret_pc;
			pc_nxt   = isr_vector;
			mie_nxt  = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			acc_r  <= or_ret_pkg::ACC_RESET;
			zero_r <= or_ret_pkg::ZERO_RESET;
			mie_r  <= or_ret_pkg::MIE_RESET;
			pc_r   <= or_ret_pkg::PC_RESET;
			pop_r  <= 1'b0;
			push_r <= 1'b0;
			pdat_r <= or_ret_pkg::PC_RESET;
			we_r   <= 1'b0;
			wd_r   <= or_ret_pkg::ACC_RESET;
			isr_r  <= 1'b0;
		end else begin
			acc_r  <= acc_nxt;
			zero_r <= zero_nxt;
			mie_r  <= mie_nxt;
			pc_r   <= pc_nxt;
			pop_r  <= pop_nxt;
			push_r <= push_nxt;
			pdat_r <= pdat_nxt;
			we_r   <= we_nxt;
			wd_r   <= wd_nxt;
			isr_r  <= isr_nxt;
		end
	end

	// every output is a bare flop, so no decode logic reaches the pins
	assign acc                     = acc_r;
	assign zero_flag               = zero_r;
	assign master_interrupt_enable = mie_r;
	assign pc                      = pc_r;
	assign stack_pop               = pop_r;
	assign stack_push              = push_r;
	assign stack_push_data         = pdat_r;
	assign mem_we                  = we_r;
	assign mem_wdata               = wd_r;
	assign isr_enter               = isr_r;

	// return from interrupt with the separate clear idle
	sequence s_return_from_interrupt_op;
		exec_valid && exec_op == or_ret_pkg::return_from_interrupt_op && !mie_clear;
	endsequence

	// the marks of a service entry, all in one cycle
	sequence s_irq_taken;
		isr_enter && stack_push && !master_interrupt_enable;
	endsequence

	a_nop_keeps_state: assert property (@(posedge clk) disable iff (!resetn) // [RL1]
		exec_valid && exec_op == or_ret_pkg::OP_NOP && !mie_clear && !(mie_r && irq_pending)
		|=> $stable(acc_r) && $stable(zero_r) && !we_r && pc_r == $past(pc_r) + 13'h0001)
		else $error("nop changed state");
	a_or_mem_acc: assert property (@(posedge clk) disable iff (!resetn) // [RL2]
		exec_valid && exec_op == or_ret_pkg::OP_OR_MEM_TO_ACC
		|=> acc == ($past(acc_r) | $past(mem_rdata)) && !mem_we)
		else $error("or memory into acc wrong");
	a_or_imm_acc: assert property (@(posedge clk) disable iff (!resetn) // [RL3]
		exec_valid && exec_op == or_ret_pkg::OP_OR_IMM_TO_ACC
		|=> acc == ($past(acc_r) | $past(imm_data)))
		else $error("or immediate into acc wrong");
	a_or_into_mem: assert property (@(posedge clk) disable iff (!resetn) // [RL4]
		exec_valid && exec_op == or_ret_pkg::or_into_memory_op
		|=> mem_we && mem_wdata == ($past(acc_r) | $past(mem_rdata)) && $stable(acc_r))
		else $error("or into memory wrong");
	a_ret_pops_pc: assert property (@(posedge clk) disable iff (!resetn) // [RL5]
		exec_valid && exec_op == or_ret_pkg::OP_RET && !(mie_r && irq_pending)
		|=> stack_pop && pc == $past(stack_top) && $stable(zero_r))
		else $error("return did not pop");
	a_ret_imm_load: assert property (@(posedge clk) disable iff (!resetn) // [RL6]
		exec_valid && exec_op == or_ret_pkg::OP_RET_IMM
		|=> stack_pop && acc == $past(imm_data) && $stable(zero_r))
		else $error("return with immediate wrong");
	a_return_from_interrupt_op_pending: assert property (@(posedge clk) disable iff (!resetn) // [RL7]
		s_return_from_interrupt_op ##0 (irq_pending && !isr_r)
		|=> s_irq_taken ##0 (pc == $past(isr_vector) && stack_push_data == $past(stack_top)))
		else $error("pending interrupt not taken on return");
	a_return_from_interrupt_op_sets_mie: assert property (@(posedge clk) disable iff (!resetn) // [RL8]
		s_return_from_interrupt_op ##0 !irq_pending |=> master_interrupt_enable && $stable(zero_r))
		else $error("return from interrupt left enable clear");
	a_mie_gates_irq: assert property (@(posedge clk) disable iff (!resetn) // [RL9]
		isr_enter |-> $past(irq_pending)
		&& ($past(exec_valid && exec_op == or_ret_pkg::return_from_interrupt_op)
		|| ($past(mie_r) && !$past(mie_clear))))
		else $error("interrupt entered while disabled");
	a_no_double_entry: assert property (@(posedge clk) disable iff (!resetn) // [RL9]
		isr_enter |=> !isr_enter)
		else $error("interrupt entered twice in a row");
	a_zero_on_or: assert property (@(posedge clk) disable iff (!resetn) // [RL10]
		exec_valid && exec_op == or_ret_pkg::OP_OR_IMM_TO_ACC
		|=> zero_flag == is_zero($past(acc_r) | $past(imm_data)))
		else $error("zero flag mismatch");
	a_zero_mem_or: assert property (@(posedge clk) disable iff (!resetn) // [RL10]
		exec_valid && (exec_op == or_ret_pkg::OP_OR_MEM_TO_ACC
		|| exec_op == or_ret_pkg::or_into_memory_op)
		|=> zero_flag == is_zero($past(acc_r) | $past(mem_rdata)))
		else $error("zero flag mismatch after memory or");
	a_return_from_interrupt_op_beats_clear: assert property (@(posedge clk) disable iff (!resetn) // [RL8]
		exec_valid && exec_op == or_ret_pkg::return_from_interrupt_op
		&& mie_clear && !irq_pending
		|=> master_interrupt_enable)
		else $error("clear overrode return from interrupt");
endmodule

/* File: testbench/tb_or_and_return_instruction_exec.sv */
// self-checking testbench for the or/return execution block
`timescale 1ns/1ps
module tb_or_and_return_instruction_exec;
	logic                               clk = 1'b0;
	logic                               resetn = 1'b0;
	logic                               exec_valid = 1'b0;
	or_ret_pkg::op_t                    exec_op = or_ret_pkg::OP_NOP;
	logic [or_ret_pkg::DATA_W-1:0]      imm_data = 8'h00;
	logic [or_ret_pkg::DATA_W-1:0]      mem_rdata = 8'h00;
	logic [or_ret_pkg::PC_W-1:0]        stack_top = 13'h0000;
	logic [or_ret_pkg::PC_W-1:0]        isr_vector = 13'h0000;
	logic                               irq_pending = 1'b0;
	logic                               mie_clear = 1'b0;
	logic [or_ret_pkg::DATA_W-1:0]      acc, mem_wdata;
	logic [or_ret_pkg::PC_W-1:0]        pc, stack_push_data;
	logic                               zero_flag, master_interrupt_enable, stack_pop;
	logic                               stack_push, mem_we, isr_enter;
	logic [15:0]                        a_s, z_s, p_s;
	int                                 n_errors = 0;
	int                                 check_count = 0;

	or_and_return_instruction_exec i_dut (.clk(clk), .resetn(resetn), .exec_valid(exec_valid),
		.exec_op(exec_op), .imm_data(imm_data), .mem_rdata(mem_rdata), .stack_top(stack_top),
		.isr_vector(isr_vector), .irq_pending(irq_pending), .mie_clear(mie_clear), .acc(acc),
		.zero_flag(zero_flag), .master_interrupt_enable(master_interrupt_enable), .pc(pc),
		.stack_pop(stack_pop), .stack_push(stack_push), .stack_push_data(stack_push_data),
		.mem_we(mem_we), .mem_wdata(mem_wdata), .isr_enter(isr_enter));

	initial begin
		forever #4 clk = ~clk;
	end

	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		check_count++;
		if (g !== e) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask

	// lets one idle edge pass first, so exec_valid never falls and rises in one step;
	// returns at the falling edge after the taking edge
	task automatic ex(input or_ret_pkg::op_t op, input logic [7:0] imm, input logic [7:0] mem,
			input logic [12:0] top);
		@(negedge clk);
		exec_op = op;
		imm_data = imm;
		mem_rdata = mem;
		stack_top = top;
		exec_valid = 1'b1;
		@(negedge clk);
		exec_valid = 1'b0;
	endtask

	task automatic t_or_forms();
		ex(or_ret_pkg::OP_RET_IMM, 8'h10, 8'h00, 13'h0040);
		chk("acc", 16'h0010, acc);
		chk("pc", 16'h0040, pc);
		chk("stack_pop", 16'h0001, stack_pop);
		ex(or_ret_pkg::OP_OR_IMM_TO_ACC, 8'h05, 8'hff, 13'h0000);
		chk("acc", 16'h0015, acc);
		chk("zero_flag", 16'h0000, zero_flag);
		ex(or_ret_pkg::OP_OR_MEM_TO_ACC, 8'hff, 8'h20, 13'h0000);
		chk("acc", 16'h0035, acc);
		chk("mem_we", 16'h0000, mem_we);
		ex(or_ret_pkg::or_into_memory_op, 8'hff, 8'h40, 13'h0000);
		chk("mem_wdata", 16'h0075, mem_wdata);
		chk("mem_we", 16'h0001, mem_we);
		chk("acc", 16'h0035, acc);
		ex(or_ret_pkg::OP_RET_IMM, 8'h00, 8'h00, 13'h0041);
		ex(or_ret_pkg::OP_OR_IMM_TO_ACC, 8'h00, 8'hff, 13'h0000);
		chk("zero_flag", 16'h0001, zero_flag);
		ex(or_ret_pkg::or_into_memory_op, 8'hff, 8'h01, 13'h0000);
		chk("zero_flag", 16'h0000, zero_flag);
		chk("mem_wdata", 16'h0001, mem_wdata);
		chk("acc", 16'h0000, acc);
		ex(or_ret_pkg::OP_OR_MEM_TO_ACC, 8'hff, 8'h00, 13'h0000);
		chk("zero_flag", 16'h0001, zero_flag);
		chk("acc", 16'h0000, acc);
		$display("test or_forms done");
	endtask

	task automatic t_nop_ret();
		a_s = acc;
		z_s = zero_flag;
		p_s = pc;
		ex(or_ret_pkg::OP_NOP, 8'hff, 8'hff, 13'h1fff);
		chk("acc", a_s, acc);
		chk("zero_flag", z_s, zero_flag);
		chk("pc", p_s + 16'h0001, pc);
		chk("mem_we", 16'h0000, mem_we);
		ex(or_ret_pkg::OP_RET, 8'h00, 8'h00, 13'h0abc);
		chk("pc", 16'h0abc, pc);
		chk("stack_pop", 16'h0001, stack_pop);
		chk("zero_flag", z_s, zero_flag);
		$display("test nop_ret done");
	endtask

	task automatic t_irq();
		irq_pending = 1'b1;
		isr_vector = 13'h1f00;
		ex(or_ret_pkg::OP_NOP, 8'h00, 8'h00, 13'h0000);
		chk("isr_enter", 16'h0000, isr_enter);
		ex(or_ret_pkg::return_from_interrupt_op, 8'h00, 8'h00, 13'h0123);
		chk("pc", 16'h1f00, pc);
		chk("isr_enter", 16'h0001, isr_enter);
		chk("stack_push", 16'h0001, stack_push);
		chk("stack_push_data", 16'h0123, stack_push_data);
		irq_pending = 1'b0;
		z_s = zero_flag;
		ex(or_ret_pkg::return_from_interrupt_op, 8'h00, 8'h00, 13'h0456);
		chk("master_interrupt_enable", 16'h0001, master_interrupt_enable);
		chk("pc", 16'h0456, pc);
		chk("zero_flag", z_s, zero_flag);
		mie_clear = 1'b1;
		@(negedge clk);
		mie_clear = 1'b0;
		chk("master_interrupt_enable", 16'h0000, master_interrupt_enable);
		irq_pending = 1'b1;
		@(negedge clk);
		chk("isr_enter", 16'h0000, isr_enter);
		irq_pending = 1'b0;
		mie_clear = 1'b1;
		ex(or_ret_pkg::return_from_interrupt_op, 8'h00, 8'h00, 13'h0789);
		mie_clear = 1'b0;
		chk("master_interrupt_enable", 16'h0001, master_interrupt_enable);
		chk("pc", 16'h0789, pc);
		$display("test irq done");
	endtask

	task automatic complete_run();
		$display("checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask

	initial begin
		#(8 * 2000);
		n_errors++;
		complete_run();
	end

	initial begin
		repeat (12) @(posedge clk);
		@(negedge clk);
		resetn = 1'b1;
		@(negedge clk);
		t_or_forms();
		t_nop_ret();
		t_irq();
		complete_run();
	end
endmodule
